// File: ast_pkg.sv
// Package for the asynchronous serial transceiver: register map, fields, types.
package ast_pkg;

    localparam logic [15:0] SERIAL_CONTROL_OFS = 16'h0098;
    localparam logic [15:0] SERIAL_BUFFER_OFS = 16'h0099;
    localparam logic [15:0] FAST_BAUD_CONTROL_OFS = 16'h00D8;
    localparam logic [15:0] BAUD_RELOAD_LOW_OFS = 16'h8068;
    localparam logic [15:0] BAUD_RELOAD_HIGH_OFS = 16'h8069;
    localparam logic [15:0] IRQ_STATUS_OFS = 16'h8070;
    localparam logic [15:0] IRQ_MASK_OFS = 16'h8071;

    localparam logic [7:0] SERIAL_CONTROL_RST = 8'h00;
    localparam logic [7:0] SERIAL_BUFFER_RST = 8'h00;
    localparam logic [7:0] FAST_BAUD_CONTROL_RST = 8'h00;
    localparam logic [9:0] BAUD_RELOAD_RST = 10'h000;
    localparam logic [1:0] IRQ_MASK_RST = 2'h3;

    localparam int CTL_MODE_BIT = 7;
    localparam int CTL_IRQ_EN_BIT = 6;
    localparam int CTL_MP_EN_BIT = 5;
    localparam int CTL_RX_EN_BIT = 4;
    localparam int CTL_TX9_BIT = 3;
    localparam int CTL_RX9_BIT = 2;
    localparam int CTL_TX_DONE_BIT = 1;
    localparam int CTL_RX_DONE_BIT = 0;
    localparam int FB_ENABLE_BIT = 7;

    localparam logic [10:0] BAUD_BASE = 11'h400;
    localparam logic [5:0] SLOW_PRESCALE = 6'h20;
    localparam logic [4:0] RX_SAMPLE_PHASE = 5'h10;
    localparam logic [3:0] MODE_A_BITS = 4'h9;
    localparam logic [3:0] MODE_B_BITS = 4'h8;

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ast_tx_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ast_rx_t;

    typedef struct packed {
        logic mode_b;
        logic irq_en;
        logic mp_en;
        logic rx_en;
        logic tx9;
        logic rx9;
        logic tx_done;
        logic rx_done;
    } ast_ctl_t;

    typedef struct packed {
        ast_ctl_t ctl;
        logic [7:0] rx_buf;
        logic fast_en;
        logic [4:0] fast_div;
        logic [9:0] reload;
        logic [1:0] irq_mask;
        logic [7:0] rdata;
        logic irq;
        logic [1:0] rx_sync;
        logic rx_prev;
        logic [15:0] tx_cnt;
        logic [5:0] tx_sub;
        ast_tx_t tx_st;
        logic [8:0] tx_sh;
        logic [3:0] tx_bits;
        logic txd;
        logic [15:0] rx_cnt;
        logic [5:0] rx_sub;
        ast_rx_t rx_st;
        logic [8:0] rx_sh;
        logic [3:0] rx_bits;
    } ast_state_t;

endpackage

// File: ast_uart.sv
// Asynchronous serial transceiver with register port and interrupt.
// Notes on behaviour
// - Writing the buffer register while the transmitter is idle loads a byte and starts a transmit frame.
// - Mode A frame: start 0, nine data bits LSB first, stop 1.
// - Receiver syncs on falling edge of receive pin and times from it.
// - Mode A receive: low eight bits to buffer, ninth to rx_ninth_bit.
// - Mode B: eight data bits, received stop bit goes to rx_ninth_bit.
// - Mode A with filter enabled: receive flag only if ninth bit is 1.
// - Done flags stay set until software writes 0 to control or 1 to status; writing 1 to control keeps them.
// - Slow rate: clock / (32 * (1024 - reload)).
// - Fast rate: clock / ((divider + 1) * (1024 - reload)).
// - Reload bits 7..0 in low register, 9..8 in high register.
// - Mode select 0 is nine-bit mode A, 1 is eight-bit mode B.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
module ast_uart
    import ast_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    output logic TXD,
    input wire logic RXD,
    output logic IRQ
);

    ast_state_t s_reg;
    ast_state_t s_next;
    logic [15:0] bit_len;
    logic [5:0] presc;
    logic [15:0] half_cnt;
    logic [5:0] half_sub;
    logic rx_fall;
    logic rx_pin;
    logic tx_end;
    logic rx_end;
    logic rx_keep;
    logic [7:0] ctl_rd;

    ////////////////////////////////////////////////////////////////////////
    // Bit time: prescale cycles per tick, (1024 - reload) ticks per bit.
    // The receiver samples in the middle of each tick run, so the fast
    // divider needs room; software must keep it at one or more to receive.

    always_comb begin
        bit_len = 16'(BAUD_BASE - {1'b0, s_reg.reload});
        if (s_reg.fast_en) begin
            presc = {1'b0, s_reg.fast_div} + 6'h01;
        end else begin
            presc = SLOW_PRESCALE;
        end
        // Starting the count half a bit in puts each later sample near the
        // centre of its bit, away from the edges where the line may move.
        half_cnt = bit_len >> 1;
        if (bit_len[0]) begin
            half_sub = presc >> 1;
        end else begin
            half_sub = 6'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        s_next = s_reg;
        tx_end = 1'b0;
        rx_end = 1'b0;
        rx_keep = 1'b0;
        // Only the second synchroniser stage feeds logic; the first one may
        // still be settling from an edge of the asynchronous receive pin.
        rx_pin = s_reg.rx_sync[1];
        rx_fall = s_reg.rx_prev && !rx_pin;
        s_next.rx_sync = {s_reg.rx_sync[0], RXD};
        s_next.rx_prev = rx_pin;

        // Transmitter. The line changes only on a bit boundary, so each bit
        // stands a full bit time for the far side.
        if (s_reg.tx_st != TX_IDLE) begin
            if (s_reg.tx_sub == presc - 6'h01) begin
                s_next.tx_sub = 6'h00;
                s_next.tx_cnt = s_reg.tx_cnt + 16'h0001;
            end else begin
                s_next.tx_sub = s_reg.tx_sub + 6'h01;
            end
        end
        if ((s_reg.tx_st != TX_IDLE) && (s_reg.tx_sub == presc - 6'h01) &&
            (s_reg.tx_cnt == bit_len - 16'h0001)) begin
            s_next.tx_cnt = 16'h0000;
            case (s_reg.tx_st)
                TX_START: begin
                    s_next.tx_st = TX_DATA;
                    s_next.txd = s_reg.tx_sh[0];
                end
                TX_DATA: begin
                    s_next.tx_sh = {1'b1, s_reg.tx_sh[8:1]};
                    s_next.tx_bits = s_reg.tx_bits - 4'h1;
                    if (s_reg.tx_bits == 4'h1) begin
                        s_next.tx_st = TX_STOP;
                        s_next.txd = 1'b1;
                    end else begin
                        s_next.txd = s_reg.tx_sh[1];
                    end
                end
                TX_STOP: begin
                    s_next.tx_st = TX_IDLE;
                    tx_end = 1'b1;
                end
                default: s_next.tx_st = TX_IDLE;
            endcase
        end

        // Receiver. An edge is only looked for while idle, so a zero data
        // bit inside a frame cannot restart the timing.
        case (s_reg.rx_st)
            RX_IDLE: begin
                if (rx_fall) begin
                    s_next.rx_st = RX_START;
                    s_next.rx_cnt = half_cnt;
                    s_next.rx_sub = half_sub;
                    s_next.rx_bits = s_reg.ctl.mode_b ? MODE_B_BITS
                                                      : MODE_A_BITS;
                end
            end
            default: begin
                if (s_reg.rx_sub == presc - 6'h01) begin
                    s_next.rx_sub = 6'h00;
                    if (s_reg.rx_cnt == bit_len - 16'h0001) begin
                        s_next.rx_cnt = 16'h0000;
                    end else begin
                        s_next.rx_cnt = s_reg.rx_cnt + 16'h0001;
                    end
                end else begin
                    s_next.rx_sub = s_reg.rx_sub + 6'h01;
                end
                if ((s_reg.rx_sub == presc - 6'h01) &&
                    (s_reg.rx_cnt == bit_len - 16'h0001)) begin
                    case (s_reg.rx_st)
                        RX_START: begin
                            // A high start sample is a glitch: drop it.
                            if (rx_pin) begin
                                s_next.rx_st = RX_IDLE;
                            end else begin
                                s_next.rx_st = RX_DATA;
                            end
                        end
                        RX_DATA: begin
                            s_next.rx_sh = {rx_pin, s_reg.rx_sh[8:1]};
                            s_next.rx_bits = s_reg.rx_bits - 4'h1;
                            if (s_reg.rx_bits == 4'h1) begin
                                s_next.rx_st = RX_STOP;
                            end
                        end
                        RX_STOP: begin
                            s_next.rx_st = RX_IDLE;
                            rx_end = 1'b1;
                        end
                        default: s_next.rx_st = RX_IDLE;
                    endcase
                end
            end
        endcase
        ////////////////////////////////////////////////////////////////////
        // Register writes.
        if (WR) begin
            case (ADDR)
                SERIAL_CONTROL_OFS: begin
                    s_next.ctl.mode_b = WDATA[CTL_MODE_BIT];
                    s_next.ctl.irq_en = WDATA[CTL_IRQ_EN_BIT];
                    s_next.ctl.mp_en = WDATA[CTL_MP_EN_BIT];
                    s_next.ctl.rx_en = WDATA[CTL_RX_EN_BIT];
                    s_next.ctl.tx9 = WDATA[CTL_TX9_BIT];
                    s_next.ctl.rx9 = WDATA[CTL_RX9_BIT];
                    if (!WDATA[CTL_TX_DONE_BIT]) begin
                        s_next.ctl.tx_done = 1'b0;
                    end
                    if (!WDATA[CTL_RX_DONE_BIT]) begin
                        s_next.ctl.rx_done = 1'b0;
                    end
                end
                SERIAL_BUFFER_OFS: begin
                    // A write during a frame is dropped, so software waits
                    // for the transmit flag before it loads the next byte.
                    if (s_reg.tx_st == TX_IDLE) begin
                        s_next.tx_st = TX_START;
                        s_next.txd = 1'b0;
                        s_next.tx_cnt = 16'h0000;
                        s_next.tx_sub = 6'h00;
                        s_next.tx_sh = {s_reg.ctl.tx9, WDATA};
                        s_next.tx_bits = s_reg.ctl.mode_b ? MODE_B_BITS
                                                          : MODE_A_BITS;
                    end
                end
                FAST_BAUD_CONTROL_OFS: begin
                    // The two gap bits are not stored and read as zero.
                    s_next.fast_en = WDATA[FB_ENABLE_BIT];
                    s_next.fast_div = WDATA[4:0];
                end
                BAUD_RELOAD_LOW_OFS: s_next.reload[7:0] = WDATA;
                BAUD_RELOAD_HIGH_OFS: s_next.reload[9:8] = WDATA[1:0];
                IRQ_STATUS_OFS: begin
                    // Second view of the done flags, cleared by a one.
                    if (WDATA[1]) begin
                        s_next.ctl.tx_done = 1'b0;
                    end
                    if (WDATA[0]) begin
                        s_next.ctl.rx_done = 1'b0;
                    end
                end
                IRQ_MASK_OFS: s_next.irq_mask = WDATA[1:0];
                default: s_next.irq_mask = s_reg.irq_mask;
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // Hardware events win over a clear in the same cycle, so a frame
        // that ends while software clears its flag is never lost.
        if (tx_end) begin
            s_next.ctl.tx_done = 1'b1;
        end
        if (rx_end && s_reg.ctl.rx_en) begin
            // In mode B the byte sits in the top eight shift bits, since the
            // stop bit is taken from the pin rather than shifted in.
            if (s_reg.ctl.mode_b) begin
                s_next.rx_buf = s_reg.rx_sh[8:1];
                s_next.ctl.rx9 = rx_pin;
                rx_keep = 1'b1;
            end else begin
                s_next.rx_buf = s_reg.rx_sh[7:0];
                s_next.ctl.rx9 = s_reg.rx_sh[8];
                rx_keep = !s_reg.ctl.mp_en || s_reg.rx_sh[8];
            end
            if (rx_keep) begin
                s_next.ctl.rx_done = 1'b1;
            end
        end

        ////////////////////////////////////////////////////////////////////
        // Read data, valid in the cycle after the strobe only.
        // Unmapped addresses read as zero.
        ctl_rd = s_reg.ctl;
        s_next.rdata = 8'h00;
        if (RD) begin
            case (ADDR)
                SERIAL_CONTROL_OFS: s_next.rdata = ctl_rd;
                SERIAL_BUFFER_OFS: s_next.rdata = s_reg.rx_buf;
                FAST_BAUD_CONTROL_OFS:
                    s_next.rdata = {s_reg.fast_en, 2'h0, s_reg.fast_div};
                BAUD_RELOAD_LOW_OFS: s_next.rdata = s_reg.reload[7:0];
                BAUD_RELOAD_HIGH_OFS:
                    s_next.rdata = {6'h00, s_reg.reload[9:8]};
                IRQ_STATUS_OFS:
                    s_next.rdata = {6'h00, s_reg.ctl.tx_done,
                                    s_reg.ctl.rx_done};
                IRQ_MASK_OFS: s_next.rdata = {6'h00, s_reg.irq_mask};
                default: s_next.rdata = 8'h00;
            endcase
        end

        // Interrupt follows the registered flags, one cycle behind.
        // Keeping it registered gives a glitch-free level at the pin.
        s_next.irq = s_reg.ctl.irq_en &&
            ((s_reg.ctl.tx_done && s_reg.irq_mask[1]) ||
             (s_reg.ctl.rx_done && s_reg.irq_mask[0]));
    end

    ////////////////////////////////////////////////////////////////////////
    // State register. The line and the edge detector start idle high,
    // so no false start bit is seen after reset.

    always_ff @(posedge CLK) begin
        if (RESET) begin
            s_reg <= '0;
            s_reg.ctl <= SERIAL_CONTROL_RST;
            s_reg.rx_buf <= SERIAL_BUFFER_RST;
            s_reg.fast_en <= FAST_BAUD_CONTROL_RST[7];
            s_reg.fast_div <= FAST_BAUD_CONTROL_RST[4:0];
            s_reg.reload <= BAUD_RELOAD_RST;
            s_reg.irq_mask <= IRQ_MASK_RST;
            s_reg.tx_st <= TX_IDLE;
            s_reg.rx_st <= RX_IDLE;
            s_reg.txd <= 1'b1;
            s_reg.rx_sync <= 2'h3;
            s_reg.rx_prev <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign RDATA = s_reg.rdata;
    assign TXD = s_reg.txd;
    assign IRQ = s_reg.irq;

endmodule

// File: ast_chk.sv
// Port assertions for the serial transceiver.
`timescale 1ns/1ns
module ast_chk
    import ast_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic IRQ
);
    wire logic ctl_wr = WR && ADDR == SERIAL_CONTROL_OFS;
    wire logic ctl_rd = RD && ADDR == SERIAL_CONTROL_OFS;
    wire logic lo_wr = WR && ADDR == BAUD_RELOAD_LOW_OFS;
    wire logic lo_rd = RD && ADDR == BAUD_RELOAD_LOW_OFS;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);
    ////////////////////////////////////////////////////////////////////////////
    a_rdata_quiet: assert property (
        !$past(RD) |-> RDATA == 8'h00) else $error("Stray read data.");
    a_hi_upper_zero: assert property (
        RD && ADDR == BAUD_RELOAD_HIGH_OFS |=> RDATA[7:2] == 6'h00)
        else $error("Reload high upper bits set.");
    a_fast_gap_zero: assert property (
        RD && ADDR == FAST_BAUD_CONTROL_OFS |=> RDATA[6:5] == 2'h0)
        else $error("Fast baud gap bits set.");
    a_flag_kept: assert property (
        ctl_rd ##1 RDATA[CTL_TX_DONE_BIT] && ctl_wr && WDATA[CTL_TX_DONE_BIT]
        ##1 ctl_rd |=> RDATA[CTL_TX_DONE_BIT]) else $error("Flag lost.");
    a_flag_clear: assert property (
        ctl_wr && !WDATA[CTL_TX_DONE_BIT] ##1 ctl_rd
        |=> !RDATA[CTL_TX_DONE_BIT]) else $error("Flag not cleared.");
    // Bits 2 to 0 are skipped since the receiver and transmitter set them.
    a_ctl_write_read: assert property (
        ctl_wr ##1 ctl_rd |=> ((RDATA ^ $past(WDATA, 2)) & 8'hF8) == 8'h00)
        else $error("Control readback differs.");
    a_reload_rw: assert property (
        lo_wr ##1 !WR ##1 lo_rd |=> RDATA == $past(WDATA, 3))
        else $error("Reload low readback differs.");
    a_irq_disabled: assert property (
        ctl_wr && !WDATA[CTL_IRQ_EN_BIT] ##1 !WR |=> !IRQ)
        else $error("Interrupt while disabled.");
endmodule

// File: ast_remote.sv
// Remote serial node: drives the receive line, captures the transmit line.
`timescale 1ns/1ns
module ast_remote (
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    // The line idles high between frames, as the remote keeps it.
    initial rxd = 1'b1;
    ////////////////////////////////////////////////////////////////////////////
    task automatic send(input logic [8:0] d, input int n, input int bt);
        for (int i = -1; i <= n; i++) begin
            @(posedge clk);
            rxd <= (i < 0) ? 1'b0 : (i == n) ? 1'b1 : d[i];
            repeat (bt - 1) @(posedge clk);
        end
    endtask
    // Start bit length is measured, so bit 0 of the sent byte must be 1.
    task automatic grab(input int n, input int bt, output logic [9:0] d,
            output int len);
        int k;
        k = 0;
        len = 0;
        d = '0;
        while (txd && k < 4000) begin
            @(posedge clk);
            k++;
        end
        while (!txd && len < 4000) begin
            @(posedge clk);
            len++;
        end
        repeat (bt / 2) @(posedge clk);
        for (int i = 0; i <= n; i++) begin
            d[i] = txd;
            repeat (bt) @(posedge clk);
        end
    endtask
endmodule

// File: ast_uart_tb.sv
// Self-checking bench for the serial transceiver.
`timescale 1ns/1ns
bind ast_uart ast_chk chk_u (.CLK(CLK), .RESET(RESET), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ));
module ast_uart_tb
    import ast_pkg::*;
;
    `define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
        err_total++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); \
        end end
    typedef struct packed {logic w; logic [15:0] a; logic [7:0] d;} ast_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic txd;
    logic rxd;
    logic irq;
    logic [9:0] fr;
    int len;
    int err_total = 0;
    int cmp_count = 0;
    ast_row_t rows [14] = '{
        '{1'b0, SERIAL_CONTROL_OFS, 8'h00}, '{1'b0, SERIAL_BUFFER_OFS, 8'h00},
        '{1'b0, FAST_BAUD_CONTROL_OFS, 8'h00}, '{1'b0, IRQ_MASK_OFS, 8'h03},
        '{1'b0, BAUD_RELOAD_LOW_OFS, 8'h00}, '{1'b0, 16'h1234, 8'h00},
        '{1'b0, BAUD_RELOAD_HIGH_OFS, 8'h00}, '{1'b1, 16'h1234, 8'hAA},
        '{1'b1, BAUD_RELOAD_LOW_OFS, 8'hFF}, '{1'b0, BAUD_RELOAD_LOW_OFS, 8'hFF},
        '{1'b1, BAUD_RELOAD_HIGH_OFS, 8'hFF}, '{1'b0, BAUD_RELOAD_HIGH_OFS, 8'h03},
        '{1'b1, FAST_BAUD_CONTROL_OFS, 8'hFF}, '{1'b0, 16'h1234, 8'h00}};
    always #10 clk = ~clk;
    ast_uart dut_u (.CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata),
        .WR(wr_s), .RD(rd_s), .RDATA(rdata), .TXD(txd), .RXD(rxd), .IRQ(irq));
    ast_remote rem_u (.clk(clk), .txd(txd), .rxd(rxd));
    ////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input logic w, input logic r, input logic [15:0] a,
            input logic [7:0] d);
        wr_s <= w;
        rd_s <= r;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cyc(1'b1, 1'b0, a, d);
        cyc(1'b0, 1'b0, a, d);
    endtask
    // Read data is taken at the second edge, before that edge updates it.
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        cyc(1'b0, 1'b1, a, 8'h00);
        cyc(1'b0, 1'b0, a, 8'h00);
        `CHK(rdata, e)
    endtask
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wirq(input logic lvl);
        int k;
        k = 0;
        while (irq !== lvl && k < 3000) begin
            cyc(1'b0, 1'b0, 16'h0000, 8'h00);
            k++;
        end
        `CHK(irq, lvl)
        if (k == 3000) begin
            test_done();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].w) begin
                wr(rows[i].a, rows[i].d);
            end else begin
                rd(rows[i].a, rows[i].d);
            end
        end
        rd(FAST_BAUD_CONTROL_OFS, 8'h9F);
        wr(FAST_BAUD_CONTROL_OFS, 8'h87);
        wr(SERIAL_CONTROL_OFS, 8'h58);
        // A second buffer write mid-frame must not disturb the frame.
        fork
            rem_u.grab(9, 8, fr, len);
            begin
                wr(SERIAL_BUFFER_OFS, 8'hA5);
                repeat (20) cyc(1'b0, 1'b0, 16'h0000, 8'h00);
                wr(SERIAL_BUFFER_OFS, 8'h00);
            end
        join
        `CHK(len, 8)
        `CHK(fr, 10'h3A5)
        wirq(1'b1);
        cyc(1'b0, 1'b1, SERIAL_CONTROL_OFS, 8'h00);
        cyc(1'b1, 1'b0, SERIAL_CONTROL_OFS, 8'h5A);
        cyc(1'b0, 1'b1, SERIAL_CONTROL_OFS, 8'h00);
        cyc(1'b1, 1'b0, SERIAL_CONTROL_OFS, 8'h58);
        `CHK(rdata, 8'h5A)
        cyc(1'b0, 1'b1, SERIAL_CONTROL_OFS, 8'h00);
        cyc(1'b0, 1'b0, SERIAL_CONTROL_OFS, 8'h00);
        `CHK(rdata, 8'h58)
        `CHK(irq, 1'b0)
        rem_u.send(9'h13C, 9, 8);
        wirq(1'b1);
        rd(SERIAL_BUFFER_OFS, 8'h3C);
        rd(SERIAL_CONTROL_OFS, 8'h5D);
        wr(SERIAL_CONTROL_OFS, 8'h78);
        rem_u.send(9'h011, 9, 8);
        repeat (10) cyc(1'b0, 1'b0, 16'h0000, 8'h00);
        `CHK(irq, 1'b0)
        rd(SERIAL_CONTROL_OFS, 8'h78);
        rd(SERIAL_BUFFER_OFS, 8'h11);
        rem_u.send(9'h122, 9, 8);
        wirq(1'b1);
        rd(SERIAL_CONTROL_OFS, 8'h7D);
        wr(SERIAL_CONTROL_OFS, 8'hD8);
        fork
            rem_u.grab(8, 8, fr, len);
            wr(SERIAL_BUFFER_OFS, 8'h81);
        join
        `CHK(fr, 10'h181)
        wr(SERIAL_CONTROL_OFS, 8'hD8);
        rem_u.send(9'h096, 8, 8);
        wirq(1'b1);
        rd(SERIAL_BUFFER_OFS, 8'h96);
        rd(SERIAL_CONTROL_OFS, 8'hDD);
        wr(SERIAL_CONTROL_OFS, 8'h58);
        wr(FAST_BAUD_CONTROL_OFS, 8'h00);
        wr(BAUD_RELOAD_LOW_OFS, 8'hFE);
        wr(IRQ_MASK_OFS, 8'h00);
        fork
            rem_u.grab(9, 64, fr, len);
            wr(SERIAL_BUFFER_OFS, 8'h01);
        join
        `CHK(len, 64)
        `CHK(fr, 10'h301)
        `CHK(irq, 1'b0)
        wr(IRQ_MASK_OFS, 8'h03);
        wirq(1'b1);
        rd(IRQ_STATUS_OFS, 8'h02);
        wr(SERIAL_CONTROL_OFS, 8'h1A);
        cyc(1'b0, 1'b0, 16'h0000, 8'h00);
        `CHK(irq, 1'b0)
        wr(SERIAL_CONTROL_OFS, 8'h5A);
        wirq(1'b1);
        wr(IRQ_STATUS_OFS, 8'h02);
        wr(IRQ_STATUS_OFS, 8'h00);
        `CHK(irq, 1'b0)
        // A reset in mid-frame must return the line and registers to idle.
        wr(SERIAL_BUFFER_OFS, 8'h55);
        `CHK(txd, 1'b0)
        rst <= 1'b1;
        repeat (2) cyc(1'b0, 1'b0, 16'h0000, 8'h00);
        `CHK(txd, 1'b1)
        `CHK(irq, 1'b0)
        rst <= 1'b0;
        rd(SERIAL_CONTROL_OFS, 8'h00);
        rd(BAUD_RELOAD_LOW_OFS, 8'h00);
        rd(IRQ_MASK_OFS, 8'h03);
        `CHK(txd, 1'b1)
        test_done();
    end
endmodule
